// ### hw/ald_map.svh
/*
 * Register offsets, field positions, reset values and timing counts for the
 * ambient light level detect block.
 * Assumes a 100 MHz clock and an APB register port with 32-bit data.
 */
`ifndef ALD_MAP_SVH
`define ALD_MAP_SVH

// byte addresses are four times the printed register index
`define ALD_IDX_DAY_PEAK      8'h05
`define ALD_IDX_OFFICE_PEAK   8'h07
`define ALD_IDX_OFFICE_DIM    8'h08
`define ALD_IDX_DARK_PEAK     8'h09
`define ALD_IDX_DARK_DIM      8'h0A
`define ALD_IDX_PRESENT       8'h0B
`define ALD_IDX_SETUP         8'h0C
`define ALD_IDX_IN_TRIP       8'h0D
`define ALD_IDX_IN_MARGIN     8'h0E
`define ALD_IDX_NT_TRIP       8'h0F
`define ALD_IDX_NT_MARGIN     8'h10
`define ALD_IDX_AUTO_CTRL     8'h14
`define ALD_IDX_LEVEL_STAT    8'h15
`define ALD_IDX_SENSOR_IN     8'h16

// setup register fields
`define ALD_SENSOR_FILTER_TIME_HI           7
`define ALD_SENSOR_FILTER_TIME_LO           5
`define ALD_FORCE_BIT         4
`define ALD_NIGHT_FLAG_BIT    3
`define ALD_INDOOR_FLAG_BIT   2
`define ALD_NIGHT_EN_BIT      1
`define ALD_INDOOR_EN_BIT     0

`define ALD_CODE_RESET        7'h00
`define ALD_BYTE_RESET        8'h00

// shortest filter time 0.08 s = 80000 us; each code doubles it
`define ALD_SENSOR_FILTER_TIME_BASE_US      80000
`define ALD_CLK_MHZ           100
`define ALD_SENSOR_FILTER_TIME_BASE_CYC     (`ALD_SENSOR_FILTER_TIME_BASE_US * `ALD_CLK_MHZ)

`endif

// ### hw/ald_pkg.sv
/*
 * Types for the ambient light level detect block.
 * Assumes nothing of its surroundings.
 */
package ald_pkg;
	typedef enum logic [1:0] {
		ALD_LVL_DAY    = 2'b01,
		ALD_LVL_OFFICE = 2'b10,
		ALD_LVL_DARK   = 2'b11
	} ald_level_e;

	typedef enum logic [1:0] {
		ALD_ST_IDLE  = 2'b00,
		ALD_ST_WAIT  = 2'b01,
		ALD_ST_CONV  = 2'b10
	} ald_state_e;
endpackage : ald_pkg

// ### hw/ald_top.sv
/*
 * Ambient light level detect: two hysteretic comparators (indoor, night),
 * filtered conversion pacing, level selection and backlight code bookkeeping,
 * all behind an APB slave.
 * Assumes the sensor code arrives synchronous to clk, scaled per channel:
 * indoor in 4 uA steps, night in 0.5 uA steps.
 */
// Register access over APB was decided locally.
// Functional notes
// - hold 7-bit dark peak current code
// - hold 7-bit dark dimmed current code
// - read-only present backlight code, writes ignored
// - filter time 0.08 s doubling per code
// - force bit triggers exactly one conversion
// - force bit self-clears when conversion done
// - night flag reports office-to-dark change
// - indoor flag reports daylight-to-office change
// - night comparator enable bit
// - indoor comparator enable bit
// - indoor flag sets below indoor trip
// - indoor flag clears above trip plus margin
// - night flag sets below night trip
// - night flag clears above trip plus margin
// - hold 7-bit daylight peak current code
// - hold office peak and dim codes
`timescale 1ns/1ns
`default_nettype none
`include "ald_map.svh"

module ald_top
	import ald_pkg::*;
#(
	parameter int unsigned SENSOR_FILTER_TIME_BASE_CYC = `ALD_SENSOR_FILTER_TIME_BASE_CYC
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_b,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// sensor and backlight side
	input  wire logic [7:0]  indoor_sense,
	input  wire logic [7:0]  night_sense,
	input  wire logic        dim_active,
	output logic      [6:0]  backlight_code,
	output logic      [1:0]  active_ambient_level
);

	logic [6:0]  day_peak;
	logic [6:0]  office_peak;
	logic [6:0]  office_dim;
	logic [6:0]  dark_peak;
	logic [6:0]  dark_dim;
	logic [2:0]  sensor_filter_time;
	logic        force_conversion;
	logic        night_detect_flag;
	logic        indoor_detect_flag;
	logic        night_comparator_enable;
	logic        indoor_comparator_enable;
	logic [7:0]  indoor_trip_threshold;
	logic [7:0]  indoor_release_margin;
	logic [7:0]  night_trip_threshold;
	logic [7:0]  night_release_margin;
	logic        automatic_brightness_enable;
	logic        conv_done;
	logic [30:0] sensor_filter_time_cnt;
	logic [30:0] sensor_filter_time_limit;
	ald_state_e  state;
	ald_level_e  next_level;
	logic [6:0]  next_code;
	logic [31:0] next_rdata;
	logic        wr_en;
	logic        rd_en;
	logic        unmapped;
	logic [7:0]  reg_idx;

	// the address decode is shared by reads and writes
	function automatic logic is_mapped(input logic [7:0] idx);
		case (idx)
			`ALD_IDX_DAY_PEAK, `ALD_IDX_OFFICE_PEAK, `ALD_IDX_OFFICE_DIM,
			`ALD_IDX_DARK_PEAK, `ALD_IDX_DARK_DIM, `ALD_IDX_PRESENT,
			`ALD_IDX_SETUP, `ALD_IDX_IN_TRIP, `ALD_IDX_IN_MARGIN,
			`ALD_IDX_NT_TRIP, `ALD_IDX_NT_MARGIN, `ALD_IDX_AUTO_CTRL,
			`ALD_IDX_LEVEL_STAT, `ALD_IDX_SENSOR_IN: is_mapped = 1'b1;
			default: is_mapped = 1'b0;
		endcase
	endfunction

	assign reg_idx  = paddr[9:2];
	assign unmapped = !is_mapped(reg_idx) || (paddr[11:10] != 2'b00) || (paddr[1:0] != 2'b00);
	// access lands on the cycle pready is sampled high
	assign wr_en    = psel && penable && pready && pwrite && !unmapped;
	assign rd_en    = psel && !penable;

	// no wait state: pready rises in the first access cycle
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && unmapped;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			day_peak    <= `ALD_CODE_RESET;
			office_peak <= `ALD_CODE_RESET;
			office_dim  <= `ALD_CODE_RESET;
			dark_peak   <= `ALD_CODE_RESET;
			dark_dim    <= `ALD_CODE_RESET;
		end else if (wr_en) begin
			case (reg_idx)
				`ALD_IDX_DAY_PEAK:    day_peak    <= pwdata[6:0];
				`ALD_IDX_OFFICE_PEAK: office_peak <= pwdata[6:0];
				`ALD_IDX_OFFICE_DIM:  office_dim  <= pwdata[6:0];
				`ALD_IDX_DARK_PEAK:   dark_peak   <= pwdata[6:0];
				`ALD_IDX_DARK_DIM:    dark_dim    <= pwdata[6:0];
				default: ;
			endcase
		end
	end

	// thresholds, margins and setup controls
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			indoor_trip_threshold       <= `ALD_BYTE_RESET;
			indoor_release_margin       <= `ALD_BYTE_RESET;
			night_trip_threshold        <= `ALD_BYTE_RESET;
			night_release_margin        <= `ALD_BYTE_RESET;
			sensor_filter_time          <= 3'h0;
			night_comparator_enable     <= 1'b0;
			indoor_comparator_enable    <= 1'b0;
			automatic_brightness_enable <= 1'b0;
		end else if (wr_en) begin
			case (reg_idx)
				`ALD_IDX_IN_TRIP:   indoor_trip_threshold <= pwdata[7:0];
				`ALD_IDX_IN_MARGIN: indoor_release_margin <= pwdata[7:0];
				`ALD_IDX_NT_TRIP:   night_trip_threshold  <= pwdata[7:0];
				`ALD_IDX_NT_MARGIN: night_release_margin  <= pwdata[7:0];
				`ALD_IDX_SETUP: begin
					sensor_filter_time       <= pwdata[`ALD_SENSOR_FILTER_TIME_HI:`ALD_SENSOR_FILTER_TIME_LO];
					night_comparator_enable  <= pwdata[`ALD_NIGHT_EN_BIT];
					indoor_comparator_enable <= pwdata[`ALD_INDOOR_EN_BIT];
				end
				`ALD_IDX_AUTO_CTRL: automatic_brightness_enable <= pwdata[0];
				default: ;
			endcase
		end
	end

	assign sensor_filter_time_limit = 31'(SENSOR_FILTER_TIME_BASE_CYC) << sensor_filter_time;

	// clear force on the converting edge, else idle re-enters a second conversion
	assign conv_done  = (state == ALD_ST_CONV);

	// conversions pace at the filter period; force asks for one now
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state     <= ALD_ST_IDLE;
			sensor_filter_time_cnt  <= 31'h0;
		end else begin
			case (state)
				ALD_ST_IDLE: begin
					sensor_filter_time_cnt <= 31'h0;
					if (force_conversion)
						state <= ALD_ST_CONV;
					else if (night_comparator_enable || indoor_comparator_enable)
						state <= ALD_ST_WAIT;
				end
				ALD_ST_WAIT: begin
					if (force_conversion) begin
						state <= ALD_ST_CONV;
					end else if (!(night_comparator_enable || indoor_comparator_enable)) begin
						state <= ALD_ST_IDLE;
					end else if (sensor_filter_time_cnt >= sensor_filter_time_limit - 31'h1) begin
						state <= ALD_ST_CONV;
					end else begin
						sensor_filter_time_cnt <= sensor_filter_time_cnt + 31'h1;
					end
				end
				ALD_ST_CONV: begin
					state <= ALD_ST_IDLE;
				end
				default: state <= ALD_ST_IDLE;
			endcase
		end
	end

	// self-clear on completion; a fresh write wins over the clear
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			force_conversion <= 1'b0;
		else if (wr_en && reg_idx == `ALD_IDX_SETUP && pwdata[`ALD_FORCE_BIT])
			force_conversion <= 1'b1;
		else if (conv_done)
			force_conversion <= 1'b0;
	end

	// forced conversions evaluate a channel even while it is disabled
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			indoor_detect_flag <= 1'b0;
			night_detect_flag  <= 1'b0;
		end else begin
			if (state == ALD_ST_CONV && (indoor_comparator_enable || force_conversion)) begin
				if (indoor_sense < indoor_trip_threshold)
					indoor_detect_flag <= 1'b1;
				else if ({1'b0, indoor_sense} > ({1'b0, indoor_trip_threshold} + {1'b0, indoor_release_margin}))
					indoor_detect_flag <= 1'b0;
			end
			if (state == ALD_ST_CONV && (night_comparator_enable || force_conversion)) begin
				if (night_sense < night_trip_threshold)
					night_detect_flag <= 1'b1;
				else if ({1'b0, night_sense} > ({1'b0, night_trip_threshold} + {1'b0, night_release_margin}))
					night_detect_flag <= 1'b0;
			end
		end
	end

	always_comb begin
		if (!automatic_brightness_enable)
			next_level = ALD_LVL_DAY;
		else if (night_detect_flag)
			next_level = ALD_LVL_DARK;
		else if (indoor_detect_flag)
			next_level = ALD_LVL_OFFICE;
		else
			next_level = ALD_LVL_DAY;
	end

	// daylight has no dim code of its own here, so its peak stands in
	always_comb begin
		case (next_level)
			ALD_LVL_DARK:   next_code = dim_active ? dark_dim : dark_peak;
			ALD_LVL_OFFICE: next_code = dim_active ? office_dim : office_peak;
			default:        next_code = day_peak;
		endcase
	end

	// present code is hardware driven only
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			backlight_code       <= `ALD_CODE_RESET;
			active_ambient_level <= 2'(ALD_LVL_DAY);
		end else begin
			backlight_code       <= next_code;
			active_ambient_level <= 2'(next_level);
		end
	end

	always_comb begin
		next_rdata = 32'h0000_0000;
		case (reg_idx)
			`ALD_IDX_DAY_PEAK:    next_rdata[6:0] = day_peak;
			`ALD_IDX_OFFICE_PEAK: next_rdata[6:0] = office_peak;
			`ALD_IDX_OFFICE_DIM:  next_rdata[6:0] = office_dim;
			`ALD_IDX_DARK_PEAK:   next_rdata[6:0] = dark_peak;
			`ALD_IDX_DARK_DIM:    next_rdata[6:0] = dark_dim;
			`ALD_IDX_PRESENT:     next_rdata[6:0] = backlight_code;
			`ALD_IDX_SETUP:       next_rdata[7:0] = {sensor_filter_time, force_conversion,
			                                         night_detect_flag, indoor_detect_flag,
			                                         night_comparator_enable, indoor_comparator_enable};
			`ALD_IDX_IN_TRIP:     next_rdata[7:0] = indoor_trip_threshold;
			`ALD_IDX_IN_MARGIN:   next_rdata[7:0] = indoor_release_margin;
			`ALD_IDX_NT_TRIP:     next_rdata[7:0] = night_trip_threshold;
			`ALD_IDX_NT_MARGIN:   next_rdata[7:0] = night_release_margin;
			`ALD_IDX_AUTO_CTRL:   next_rdata[0]   = automatic_brightness_enable;
			`ALD_IDX_LEVEL_STAT:  next_rdata[1:0] = active_ambient_level;
			`ALD_IDX_SENSOR_IN:   next_rdata[15:0] = {night_sense, indoor_sense};
			default: ;
		endcase
	end

	// read data captured in setup, held through access
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			prdata <= 32'h0000_0000;
		else if (rd_en)
			prdata <= (pwrite || unmapped) ? 32'h0000_0000 : next_rdata;
	end

endmodule : ald_top
`default_nettype wire

// ### dv/ald_top_properties.sv
/*
 * Checker for ald_top: apb answer timing, error replies, read data, level.
 * Assumes it is bound to ald_top and sees only its ports.
 */
`timescale 1ns/1ns
`default_nettype none
`include "ald_map.svh"

module ald_top_properties
	import ald_pkg::*;
#(
	parameter int unsigned SENSOR_FILTER_TIME_BASE_CYC = 20
) (
	// clock and reset
	input wire logic        clk,
	input wire logic        rst_b,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// backlight
	input wire logic [6:0]  backlight_code,
	input wire logic [1:0]  active_ambient_level
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	wire logic setup = psel && !penable;

	a_ready_after_setup: assert property (setup |=> pready)
		else $error("no pready after setup");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_error_with_ready: assert property (pslverr |-> pready && psel && penable)
		else $error("pslverr outside access");
	a_misaligned_error: assert property (setup && paddr[1:0] != 2'b00 |=> pslverr)
		else $error("misaligned access not refused");
	a_hole_reads_zero: assert property (setup && paddr[9:2] == 8'h06 |=> pslverr && prdata == 32'h0)
		else $error("unmapped index answered");
	a_present_readback: assert property (setup && !pwrite && paddr == {2'b00, `ALD_IDX_PRESENT, 2'b00}
		|=> prdata == {25'h0, $past(backlight_code)})
		else $error("present code read differs from output");
	a_setup_upper_zero: assert property (setup && !pwrite && paddr == {2'b00, `ALD_IDX_SETUP, 2'b00}
		|=> prdata[31:8] == 24'h0 && !pslverr)
		else $error("setup read upper bits set");
	a_level_legal: assert property (active_ambient_level != 2'b00)
		else $error("ambient level code zero");
endmodule // ald_top_properties

bind ald_top ald_top_properties #(.SENSOR_FILTER_TIME_BASE_CYC(SENSOR_FILTER_TIME_BASE_CYC)) i_ald_top_properties (.clk(clk), .rst_b(rst_b),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .backlight_code(backlight_code), .active_ambient_level(active_ambient_level));
`default_nettype wire

// ### dv/ald_top_test.sv
/*
 * Bench for ald_top: registers, comparators, forced conversion.
 * Assumes SENSOR_FILTER_TIME_BASE_CYC shortened to 20 cycles.
 */
`timescale 1ns/1ns
`default_nettype none
`include "ald_map.svh"

module ald_top_test
	import ald_pkg::*;
;
	localparam int FB = 20;
	logic        clk, rst_b, psel, penable, pwrite, dim_active, pready, pslverr, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0]  indoor_sense, night_sense;
	logic [6:0]  backlight_code;
	logic [1:0]  active_ambient_level;
	int          miscompares, check_count;

	ald_top #(.SENSOR_FILTER_TIME_BASE_CYC(FB)) i_ald_top (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .indoor_sense(indoor_sense), .night_sense(night_sense),
		.dim_active(dim_active), .backlight_code(backlight_code),
		.active_ambient_level(active_ambient_level));

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	// pready, prdata and pslverr taken at the rising edge; release at that same edge
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			miscompares++;
			give_verdict();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] ix, input logic [31:0] d);
		apb({2'b00, ix, 2'b00}, 1'b1, d);
	endtask

	task automatic rdck(input logic [7:0] ix, input logic [31:0] e);
		apb({2'b00, ix, 2'b00}, 1'b0, 32'h0);
		chk(rd, e);
	endtask

	// waits three filter periods so at least two conversions land
	task automatic step(input logic [7:0] ins, input logic [7:0] nts, input logic dm,
		input logic [1:0] fl, input logic [1:0] lv, input logic [6:0] code);
		indoor_sense <= ins;
		night_sense <= nts;
		dim_active <= dm;
		repeat (3 * FB) @(posedge clk);
		rdck(`ALD_IDX_SETUP, {28'h0, fl, 2'b11});
		chk({30'h0, active_ambient_level}, {30'h0, lv});
		chk({25'h0, backlight_code}, {25'h0, code});
	endtask

	task automatic t_regs();
		logic [7:0] ix [9] = '{`ALD_IDX_DAY_PEAK, `ALD_IDX_OFFICE_PEAK, `ALD_IDX_OFFICE_DIM,
			`ALD_IDX_DARK_PEAK, `ALD_IDX_DARK_DIM, `ALD_IDX_IN_TRIP, `ALD_IDX_IN_MARGIN,
			`ALD_IDX_NT_TRIP, `ALD_IDX_NT_MARGIN};
		logic [31:0] m;
		for (int i = 0; i < 9; i++) begin
			m = (i < 5) ? 32'h7F : 32'hFF;
			rdck(ix[i], 32'h0);
			wr(ix[i], 32'hFFFFFF80 | (i + 1));
			rdck(ix[i], (32'hFFFFFF80 | (i + 1)) & m);
		end
		wr(`ALD_IDX_PRESENT, 32'hFF);
		rdck(`ALD_IDX_PRESENT, 32'h01);
		chk({25'h0, backlight_code}, 32'h01);
		apb(12'h018, 1'b0, 32'h0);
		chk({31'h0, er}, 32'h1);
		chk(rd, 32'h0);
		apb(12'h025, 1'b1, 32'hFF);
		chk({31'h0, er}, 32'h1);
	endtask

	task automatic t_compare();
		wr(`ALD_IDX_AUTO_CTRL, 32'h1);
		wr(`ALD_IDX_IN_TRIP, 32'h40);
		wr(`ALD_IDX_IN_MARGIN, 32'h10);
		wr(`ALD_IDX_NT_TRIP, 32'h20);
		wr(`ALD_IDX_NT_MARGIN, 32'h08);
		wr(`ALD_IDX_SETUP, 32'h03);
		step(8'h80, 8'h80, 1'b0, 2'b00, ALD_LVL_DAY, 7'h01);
		step(8'h3F, 8'h80, 1'b0, 2'b01, ALD_LVL_OFFICE, 7'h02);
		step(8'h3F, 8'h80, 1'b1, 2'b01, ALD_LVL_OFFICE, 7'h03);
		step(8'h50, 8'h80, 1'b1, 2'b01, ALD_LVL_OFFICE, 7'h03);
		step(8'h51, 8'h80, 1'b1, 2'b00, ALD_LVL_DAY, 7'h01);
		step(8'h3F, 8'h1F, 1'b1, 2'b11, ALD_LVL_DARK, 7'h05);
		step(8'h3F, 8'h1F, 1'b0, 2'b11, ALD_LVL_DARK, 7'h04);
		step(8'h3F, 8'h28, 1'b0, 2'b11, ALD_LVL_DARK, 7'h04);
		step(8'h3F, 8'h29, 1'b0, 2'b01, ALD_LVL_OFFICE, 7'h02);
	endtask

	task automatic t_force();
		wr(`ALD_IDX_SETUP, 32'hE0);
		indoor_sense <= 8'hFF;
		night_sense <= 8'h00;
		repeat (3 * FB) @(posedge clk);
		rdck(`ALD_IDX_SETUP, 32'hE4);
		wr(`ALD_IDX_SETUP, 32'hF0);
		for (int n = 0; n < 10; n++) begin
			apb({2'b00, `ALD_IDX_SETUP, 2'b00}, 1'b0, 32'h0);
			if (rd[4] === 1'b0)
				break;
		end
		chk(rd, 32'hE8);
		chk({30'h0, active_ambient_level}, {30'h0, ALD_LVL_DARK});
		night_sense <= 8'hFF;
		repeat (3 * FB) @(posedge clk);
		rdck(`ALD_IDX_SETUP, 32'hE8);
	endtask

	// code 001 doubles the period to 2*FB: nothing yet at 32 cycles, done by 55
	task automatic t_filter();
		indoor_sense <= 8'h00;
		wr(`ALD_IDX_SETUP, 32'h21);
		repeat (30) @(posedge clk);
		rdck(`ALD_IDX_SETUP, 32'h29);
		repeat (20) @(posedge clk);
		rdck(`ALD_IDX_SETUP, 32'h2D);
		rdck(`ALD_IDX_LEVEL_STAT, {30'h0, ALD_LVL_DARK});
		rdck(`ALD_IDX_SENSOR_IN, 32'h0000FF00);
		chk({25'h0, backlight_code}, 32'h04);
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		rst_b = 1'b0;
		{psel, penable, pwrite, dim_active} = 4'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		indoor_sense = 8'hFF;
		night_sense = 8'hFF;
		miscompares = 0;
		check_count = 0;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		t_regs();
		t_compare();
		t_force();
		t_filter();
		give_verdict();
	end
endmodule // ald_top_test
`default_nettype wire
